//--- lcdtim_timing.sv
// Line and frame timing generator of the LCD controller with register port.
// Summary of operation
// - Line back porch bits 31:24 gives value+1 pixel clocks before pixels.
// - Line front porch bits 23:16 gives value+1 clocks before line clock.
// - Bits 15:8 give line clock or horizontal sync width, value+1.
// - Bits 7:2 give 16 times (value+1) active pixels per line.
// - Active pixels are counted; front porch starts once count completes.
// - A data request pulses at the start of every display line.
// - Frame back porch bits 31:24 gives 0-255 lines after sync ends.
// - Frame front porch lines follow active lines, then the frame sync.
// - Frame sync width is the 6-bit value plus one lines.
// - Active lines per panel are the 10-bit value plus one.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module lcdtim_timing
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic lineClock,
  output logic frame_sync_out,
  output logic dataEnable,
  output logic dmaRequest,
  output logic lineActive
);
  logic [31:0] horizTiming_q, horizTiming_d;
  logic [31:0] vertTiming_q, vertTiming_d;
  logic [1:0] control_q, control_d;
  logic [31:0] regRdData_q, regRdData_d;
  lcdtim_pkg::lcdtim_phase_t hPhase_q, hPhase_d;
  lcdtim_pkg::lcdtim_phase_t vPhase_q, vPhase_d;
  logic [10:0] hCount_q, hCount_d;
  logic [10:0] vCount_q, vCount_d;
  logic lineClock_q, lineClock_d;
  logic frameSync_q, frameSync_d;
  logic dataEnable_q, dataEnable_d;
  logic dmaRequest_q, dmaRequest_d;
  logic enable;
  logic lineDone;
  logic [7:0] lineBackPorch, lineFrontPorch, lineSyncWidth;
  logic [5:0] pixelsPerLineCode;
  logic [7:0] frameBackPorch, frameFrontPorch;
  logic [5:0] frameSyncWidth;
  logic [9:0] linesPerPanelCode;

  // Field extraction of a byte wide field at a given low bit.
  function automatic logic [7:0] fieldByte(input logic [31:0] r, input int lsb);
    fieldByte = r[lsb +: 8];
  endfunction

  assign enable = control_q[lcdtim_pkg::CTRL_ENABLE_BIT];
  assign lineBackPorch = fieldByte(horizTiming_q,
    lcdtim_pkg::LINE_BACK_PORCH_LSB);
  assign lineFrontPorch = fieldByte(horizTiming_q,
    lcdtim_pkg::LINE_FRONT_PORCH_LSB);
  assign lineSyncWidth = fieldByte(horizTiming_q,
    lcdtim_pkg::LINE_SYNC_WIDTH_LSB);
  assign pixelsPerLineCode =
    horizTiming_q[lcdtim_pkg::PIXELS_PER_LINE_CODE_LSB +: 6];
  assign frameBackPorch = fieldByte(vertTiming_q,
    lcdtim_pkg::FRAME_BACK_PORCH_LSB);
  assign frameFrontPorch = fieldByte(vertTiming_q,
    lcdtim_pkg::FRAME_FRONT_PORCH_LSB);
  assign frameSyncWidth = vertTiming_q[lcdtim_pkg::FRAME_SYNC_WIDTH_LSB +: 6];
  assign linesPerPanelCode =
    vertTiming_q[lcdtim_pkg::LINES_PER_PANEL_CODE_LSB +: 10];

  // Register port; timing fields should only change while disabled.
  always_comb
  begin
    horizTiming_d = horizTiming_q;
    vertTiming_d = vertTiming_q;
    control_d = control_q;
    regRdData_d = 32'h00000000;
    if (regWrite)
    begin
      unique case (regAddr)
        lcdtim_pkg::HORIZ_TIMING_ADDR:
          horizTiming_d = regWrData & lcdtim_pkg::HORIZ_WRITE_MASK;
        lcdtim_pkg::VERT_TIMING_ADDR:
          vertTiming_d = regWrData & lcdtim_pkg::VERT_WRITE_MASK;
        lcdtim_pkg::CONTROL_ADDR:
          control_d = regWrData[1:0];
        default:
          control_d = control_q;
      endcase
    end
    if (regRead)
    begin
      unique case (regAddr)
        lcdtim_pkg::HORIZ_TIMING_ADDR: regRdData_d = horizTiming_q;
        lcdtim_pkg::VERT_TIMING_ADDR: regRdData_d = vertTiming_q;
        lcdtim_pkg::CONTROL_ADDR: regRdData_d = {30'h00000000, control_q};
        lcdtim_pkg::STATUS_ADDR:
          regRdData_d = {16'h0000, 1'b0, vCount_q, vPhase_q, hPhase_q};
        default: regRdData_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      horizTiming_q <= lcdtim_pkg::HORIZ_TIMING_RESET;
      vertTiming_q <= lcdtim_pkg::VERT_TIMING_RESET;
      control_q <= lcdtim_pkg::CONTROL_RESET;
      regRdData_q <= 32'h00000000;
    end
    else
    begin
      horizTiming_q <= horizTiming_d;
      vertTiming_q <= vertTiming_d;
      control_q <= control_d;
      regRdData_q <= regRdData_d;
    end
  end

  // A line ends with the last cycle of its sync pulse.
  assign lineDone = (hPhase_q == lcdtim_pkg::LCDTIM_SYNC) &&
    (hCount_q[7:0] == lineSyncWidth);

  // Horizontal sequencer; porch and sync counts run from zero up to the field value.
  always_comb
  begin
    hPhase_d = hPhase_q;
    hCount_d = hCount_q + 11'h001;
    dmaRequest_d = 1'b0;
    if (!enable)
    begin
      hPhase_d = lcdtim_pkg::LCDTIM_BACK;
      hCount_d = 11'h000;
    end
    else
    begin
      unique case (hPhase_q)
        lcdtim_pkg::LCDTIM_BACK:
          if (hCount_q[7:0] == lineBackPorch)
          begin
            hPhase_d = lcdtim_pkg::LCDTIM_ACTIVE;
            hCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_ACTIVE:
          if (hCount_q == ({5'h00, pixelsPerLineCode} + 11'h001) *
              lcdtim_pkg::PIXEL_GROUP - 11'h001)
          begin
            hPhase_d = lcdtim_pkg::LCDTIM_FRONT;
            hCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_FRONT:
          if (hCount_q[7:0] == lineFrontPorch)
          begin
            hPhase_d = lcdtim_pkg::LCDTIM_SYNC;
            hCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_SYNC:
          if (lineDone)
          begin
            hPhase_d = lcdtim_pkg::LCDTIM_BACK;
            hCount_d = 11'h000;
          end
      endcase
      // request at line start
      // The second term gives the first line after enable its request.
      dmaRequest_d = lineDone ||
        (hPhase_q == lcdtim_pkg::LCDTIM_BACK && hCount_q == 11'h000 &&
         !dmaRequest_q);
    end
  end

  // Vertical sequencer, stepping once per finished line. A porch field of
  // zero skips its phase, so a porch lasts exactly its field value in lines.
  always_comb
  begin
    vPhase_d = vPhase_q;
    vCount_d = vCount_q;
    if (!enable)
    begin
      vPhase_d = lcdtim_pkg::LCDTIM_BACK;
      vCount_d = 11'h000;
    end
    else if (lineDone)
    begin
      vCount_d = vCount_q + 11'h001;
      unique case (vPhase_q)
        lcdtim_pkg::LCDTIM_BACK:
          if (vCount_q[7:0] + 8'h01 >= frameBackPorch)
          begin
            vPhase_d = lcdtim_pkg::LCDTIM_ACTIVE;
            vCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_ACTIVE:
          if (vCount_q[9:0] == linesPerPanelCode)
          begin
            vPhase_d = (frameFrontPorch == 8'h00) ? lcdtim_pkg::LCDTIM_SYNC :
              lcdtim_pkg::LCDTIM_FRONT;
            vCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_FRONT:
          if (vCount_q[7:0] + 8'h01 >= frameFrontPorch)
          begin
            vPhase_d = lcdtim_pkg::LCDTIM_SYNC;
            vCount_d = 11'h000;
          end
        lcdtim_pkg::LCDTIM_SYNC:
          if (vCount_q[5:0] == frameSyncWidth)
          begin
            vPhase_d = (frameBackPorch == 8'h00) ? lcdtim_pkg::LCDTIM_ACTIVE :
              lcdtim_pkg::LCDTIM_BACK;
            vCount_d = 11'h000;
          end
      endcase
    end
    else if (vPhase_q == lcdtim_pkg::LCDTIM_BACK &&
             frameBackPorch == 8'h00)
    begin
      vPhase_d = lcdtim_pkg::LCDTIM_ACTIVE;
    end
  end

  // Outputs are registered from the next phase so they align with it.
  always_comb
  begin
    lineClock_d = enable && (hPhase_d == lcdtim_pkg::LCDTIM_SYNC);
    frameSync_d = enable && (vPhase_d == lcdtim_pkg::LCDTIM_SYNC);
    dataEnable_d = enable && (hPhase_d == lcdtim_pkg::LCDTIM_ACTIVE) &&
      (vPhase_d == lcdtim_pkg::LCDTIM_ACTIVE);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hPhase_q <= lcdtim_pkg::LCDTIM_BACK;
      vPhase_q <= lcdtim_pkg::LCDTIM_BACK;
      hCount_q <= 11'h000;
      vCount_q <= 11'h000;
      lineClock_q <= 1'b0;
      frameSync_q <= 1'b0;
      dataEnable_q <= 1'b0;
      dmaRequest_q <= 1'b0;
    end
    else
    begin
      hPhase_q <= hPhase_d;
      vPhase_q <= vPhase_d;
      hCount_q <= hCount_d;
      vCount_q <= vCount_d;
      lineClock_q <= lineClock_d;
      frameSync_q <= frameSync_d;
      dataEnable_q <= dataEnable_d;
      dmaRequest_q <= dmaRequest_d;
    end
  end

  assign regRdData = regRdData_q;
  assign lineClock = lineClock_q;
  assign frame_sync_out = frameSync_q;
  assign dataEnable = dataEnable_q;
  assign dmaRequest = dmaRequest_q;
  assign lineActive = (hPhase_q == lcdtim_pkg::LCDTIM_ACTIVE);
endmodule
`default_nettype wire

//--- lcdtim_pkg.sv
// Package with register map, field layout and state codes of the LCD timing block.
package lcdtim_pkg;
  localparam logic [31:0] HORIZ_TIMING_ADDR = 32'h31040000;
  localparam logic [31:0] VERT_TIMING_ADDR = 32'h31040004;
  localparam logic [31:0] CONTROL_ADDR = 32'h31040040;
  localparam logic [31:0] STATUS_ADDR = 32'h31040044;
  localparam logic [31:0] HORIZ_TIMING_RESET = 32'h00000000;
  localparam logic [31:0] VERT_TIMING_RESET = 32'h00000000;
  localparam int LINE_BACK_PORCH_LSB = 24;
  localparam int LINE_FRONT_PORCH_LSB = 16;
  localparam int LINE_SYNC_WIDTH_LSB = 8;
  localparam int PIXELS_PER_LINE_CODE_LSB = 2;
  localparam int FRAME_BACK_PORCH_LSB = 24;
  localparam int FRAME_FRONT_PORCH_LSB = 16;
  localparam int FRAME_SYNC_WIDTH_LSB = 10;
  localparam int LINES_PER_PANEL_CODE_LSB = 0;
  localparam logic [31:0] HORIZ_WRITE_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] VERT_WRITE_MASK = 32'hFFFFFFFF;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PASSIVE_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [10:0] PIXEL_GROUP = 11'h010;

  typedef enum logic [1:0]
  {
    LCDTIM_BACK = 2'b00,
    LCDTIM_ACTIVE = 2'b01,
    LCDTIM_FRONT = 2'b10,
    LCDTIM_SYNC = 2'b11
  } lcdtim_phase_t;
endpackage

//--- lcdtim_timing_sva.sv
// Checker of line timing relations at the timing block ports.
`timescale 1ns/100ps
`default_nettype none
module lcdtim_timing_sva
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic lineClock,
  input wire logic frame_sync_out,
  input wire logic dataEnable,
  input wire logic dmaRequest,
  input wire logic lineActive
);
  logic [31:0] h_q;
  logic en_q, syn_q, pxl_q;
  logic [15:0] hi_q, px_q, lo_q;
  logic [31:0] v_q;
  logic lcp_q, fsd_q, act_q;
  logic [7:0] fsl_q, bpl_q, fpl_q;
  wire lcRise = lineClock && !lcp_q;
  wire ctlWr = regWrite && regAddr == lcdtim_pkg::CONTROL_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Run lengths let each gap be compared with its field plus one.
  always_ff @(posedge clk)
  begin
    if (sys_rst || (regWrite && regAddr == lcdtim_pkg::HORIZ_TIMING_ADDR))
      h_q <= sys_rst ? 32'h0 : regWrData;
    if (sys_rst || ctlWr)
      en_q <= !sys_rst && regWrData[0];
    syn_q <= !sys_rst && (lineClock || (syn_q && !ctlWr));
    pxl_q <= !sys_rst && (dataEnable || (pxl_q && !lineClock));
    hi_q <= lineClock ? hi_q + 16'h1 : 16'h0;
    px_q <= dataEnable ? px_q + 16'h1 : 16'h0;
    lo_q <= (lineClock || dataEnable) ? 16'h0 : lo_q + 16'h1;
    // Line counts per frame phase are taken from line clock rises.
    if (sys_rst || (regWrite && regAddr == lcdtim_pkg::VERT_TIMING_ADDR))
      v_q <= sys_rst ? 32'h0 : regWrData;
    lcp_q <= lineClock;
    fsd_q <= !sys_rst && (frame_sync_out || (fsd_q && !dataEnable && !ctlWr));
    act_q <= !sys_rst && (dataEnable || (act_q && !frame_sync_out && !ctlWr));
    fsl_q <= frame_sync_out ? fsl_q + 8'(lcRise) : 8'h0;
    bpl_q <= frame_sync_out ? 8'h0 : bpl_q + 8'(lcRise);
    fpl_q <= dataEnable ? 8'h0 : fpl_q + 8'(lcRise);
  end
  property p_rd; !$past(regRead) |-> regRdData == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_dma; dmaRequest |=> !dmaRequest; endproperty
  a_dma: assert property (p_dma) else $error("long data request");
  property p_exc; dataEnable |-> !lineClock && !frame_sync_out; endproperty
  a_exc: assert property (p_exc) else $error("pixel during sync");
  property p_sw;
    en_q && $fell(lineClock) |-> hi_q == {8'h0, h_q[15:8]} + 16'h1;
  endproperty
  a_sw: assert property (p_sw) else $error("line clock width");
  property p_ppl;
    en_q && $fell(dataEnable) |-> px_q == {6'h0, h_q[7:2], 4'h0} + 16'h10;
  endproperty
  a_ppl: assert property (p_ppl) else $error("pixels per line");
  property p_fp;
    en_q && $rose(lineClock) && pxl_q |-> lo_q == {8'h0, h_q[23:16]} + 16'h1;
  endproperty
  a_fp: assert property (p_fp) else $error("front porch");
  property p_bp;
    en_q && $rose(dataEnable) && syn_q |-> lo_q == {8'h0, h_q[31:24]} + 16'h1;
  endproperty
  a_bp: assert property (p_bp) else $error("back porch");
  property p_off;
    !en_q && !$past(en_q) && !$past(en_q, 2) |-> !lineClock && !dataEnable;
  endproperty
  a_off: assert property (p_off) else $error("output while off");
  property p_fsw;
    en_q && $fell(frame_sync_out) |-> fsl_q == {2'h0, v_q[15:10]} + 8'h01;
  endproperty
  a_fsw: assert property (p_fsw) else $error("frame sync width");
  property p_vbp;
    en_q && $rose(dataEnable) && fsd_q |-> bpl_q == v_q[31:24];
  endproperty
  a_vbp: assert property (p_vbp) else $error("frame back porch");
  property p_vfp;
    en_q && $rose(frame_sync_out) && act_q |-> fpl_q == v_q[23:16] + 8'h01;
  endproperty
  a_vfp: assert property (p_vfp) else $error("frame front porch");
  property p_act; dataEnable |-> lineActive; endproperty
  a_act: assert property (p_act) else $error("pixel outside active");
  property p_dmal; en_q && $fell(lineClock) |-> dmaRequest; endproperty
  a_dmal: assert property (p_dmal) else $error("no line request");
endmodule
bind lcdtim_timing lcdtim_timing_sva lcdtim_timing_sva_i
(
  .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .lineClock(lineClock), .frame_sync_out(frame_sync_out),
  .dataEnable(dataEnable), .dmaRequest(dmaRequest), .lineActive(lineActive)
);
`default_nettype wire

//--- lcdtim_panel.sv
// Panel model counting pixels of a row and pixel rows of a frame.
`timescale 1ns/100ps
`default_nettype none
module lcdtim_panel
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frameSync,
  input wire logic dataEnable,
  output logic [15:0] linePixels,
  output logic [15:0] frameLines,
  output logic [15:0] frames
);
  logic [15:0] px_q, ln_q;
  logic de_q, fs_q;
  always_ff @(posedge clk)
  begin
    de_q <= dataEnable;
    fs_q <= frameSync;
    px_q <= dataEnable ? px_q + 16'h1 : 16'h0;
    if (de_q && !dataEnable)
      linePixels <= px_q;
    if (fs_q && !frameSync)
      frameLines <= ln_q;
    ln_q <= (fs_q && !frameSync) ? 16'h0 : ln_q + 16'(de_q && !dataEnable);
    frames <= sys_rst ? 16'h0 : frames + 16'(fs_q && !frameSync);
  end
endmodule
`default_nettype wire

//--- tb_lcdtim_timing.sv
// Testbench of the LCD line and frame timing block.
`timescale 1ns/100ps
`default_nettype none
module tb_lcdtim_timing;
  localparam logic [31:0] HA = lcdtim_pkg::HORIZ_TIMING_ADDR;
  localparam logic [31:0] VA = lcdtim_pkg::VERT_TIMING_ADDR;
  localparam logic [31:0] CA = lcdtim_pkg::CONTROL_ADDR;
  // Sync, back and front porch fields of each run.
  localparam logic [23:0] HCFG [5] = '{24'h000000, 24'h020207, 24'h030505,
    24'h060A03, 24'h00FFFF};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [31:0] regAddr = 32'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic [31:0] regRdData, hv;
  logic lineClock, frameSync, dataEnable, dmaRequest;
  logic [15:0] linePixels, frameLines, frames;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'hb0ea682c;
  always #25 clk = ~clk;
  lcdtim_timing lcdtim_timing_i
  (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .lineClock(lineClock), .frame_sync_out(frameSync),
    .dataEnable(dataEnable), .dmaRequest(dmaRequest), .lineActive()
  );
  lcdtim_panel lcdtim_panel_i
  (
    .clk(clk), .sys_rst(sys_rst), .frameSync(frameSync),
    .dataEnable(dataEnable), .linePixels(linePixels),
    .frameLines(frameLines), .frames(frames)
  );
  task automatic test_done();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    @(negedge clk);
    chk(regRdData, e);
  endtask
  // passive runs keep the frame back porch at zero for contrast.
  task automatic run(input int i);
    logic [7:0] sw, bp, fp, vb;
    logic [5:0] pixels_per_line_code;
    logic [9:0] lines_per_panel_code;
    logic pas;
    {sw, bp, fp} = HCFG[i];
    pas = i > 0 && i < 4;
    pixels_per_line_code = 6'($random(seed) & 3);
    lines_per_panel_code = 10'($random(seed) & 7);
    vb = pas ? 8'h0 : 8'($random(seed) & 3);
    wr(CA, 32'h0);
    wr(HA, {bp, fp, sw, pixels_per_line_code, 2'h0});
    wr(VA, {vb, 8'($random(seed) & 3), 6'($random(seed) & 3), lines_per_panel_code});
    wr(CA, {30'h0, pas, 1'h1});
    hv = {16'h0, frames + 16'h2};
    for (int k = 0; k < 40000 && {16'h0, frames} !== hv; k++)
      @(posedge clk);
    chk({16'h0, frames}, hv);
    chk({16'h0, linePixels}, 32'(16 * (pixels_per_line_code + 1)));
    chk({16'h0, frameLines}, 32'(lines_per_panel_code) + 32'h1);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    rd(HA, lcdtim_pkg::HORIZ_TIMING_RESET);
    rd(VA, lcdtim_pkg::VERT_TIMING_RESET);
    rd(32'h31040010, 32'h0);
    rd(lcdtim_pkg::STATUS_ADDR, 32'h0);
    rd(CA, 32'h0);
    hv = $random(seed) & lcdtim_pkg::HORIZ_WRITE_MASK;
    wr(HA, hv);
    rd(HA, hv & lcdtim_pkg::HORIZ_WRITE_MASK);
    hv = $random(seed);
    wr(VA, hv);
    rd(VA, hv);
    for (int i = 0; i < 5; i++)
      run(i);
    test_done();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
